// ===== rtw_timer.sv
// design: eight-bit reload timer with watchdog and timer output, AHB-Lite slave
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// What this block does
// - count up per tick; tick at FF overflows
// - overflow reloads write value or restarts zero
// - overflow sets sticky interrupt flag bit two
// - watchdog enabled overflow resets the chip
// - mode bit three selects reload or free-run
// - mode bits two..zero pick tick period
// - mode write effective two cycles later
// - output mode field decodes five modes
// - non-port mode claims pin, low after reset
// - toggle mode inverts output per overflow
// - force-0 mode drives low on overflow
// - force-1 mode drives high on overflow
// - PWM mode gives fixed half duty pulse train, flipping per overflow
// - low digit stored, high digit loads counter
// - high write alone reuses retained low digit
// - reset clears low digit, high undefined
// - high read latches low count for later
// - shared addresses: writes load, reads count
// - eleven-bit prescaler free runs from reset
module rtw_timer
    import rtw_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // timer side
    output logic             o_timer_out,
    output logic             o_pin_is_timer,
    output logic             o_irq_flag,
    output logic             o_chip_reset
);

    // ==========================================================
    // bus address phase capture
    rtw_req_s req_ff;
    rtw_req_s nxt_req;
    logic     acc;

    assign acc = hsel & hready & htrans[1];
    always_comb begin
        nxt_req.wr  = acc & hwrite;
        nxt_req.rd  = acc & ~hwrite;
        nxt_req.idx = haddr[13:2];
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            req_ff <= '0;
        end else begin
            req_ff <= nxt_req;
        end
    end

    // zero wait state, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    logic wr_mode;
    logic wr_low;
    logic wr_high;
    logic wr_out;
    logic wr_irq;
    logic wr_wdog;
    logic rd_high;

    assign wr_mode = req_ff.wr & (req_ff.idx == MODE_SEL_IDX);
    assign wr_low  = req_ff.wr & (req_ff.idx == LOAD_LOW_IDX);
    assign wr_high = req_ff.wr & (req_ff.idx == LOAD_HIGH_IDX);
    assign wr_out  = req_ff.wr & (req_ff.idx == OUT_MODE_IDX);
    assign wr_irq  = req_ff.wr & (req_ff.idx == IRQ_FLAG_IDX);
    assign wr_wdog = req_ff.wr & (req_ff.idx == WDOG_IDX);
    assign rd_high = req_ff.rd & (req_ff.idx == LOAD_HIGH_IDX);

    // ==========================================================
    // prescaler and instruction cycle strobe
    logic [PRESCALE_W-1:0] pre_ff;
    logic [7:0]            icyc_cnt_ff;
    logic                  icyc;

    assign icyc = (icyc_cnt_ff == 8'(INSTR_CYC_CLKS - 1));
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            icyc_cnt_ff <= 8'h00;
        end else if (icyc) begin
            icyc_cnt_ff <= 8'h00;
        end else begin
            icyc_cnt_ff <= icyc_cnt_ff + 8'h01;
        end
    end

    // no stop mode here, so it only halts in reset
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pre_ff <= '0;
        end else if (icyc) begin
            pre_ff <= pre_ff + 11'h001;
        end
    end

    // ==========================================================
    // mode register with delayed take-effect
    logic [3:0] mode_pend_ff;
    logic [3:0] mode_ff;
    logic [1:0] mode_dly_ff;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mode_pend_ff <= MODE_SEL_RST;
            mode_ff      <= MODE_SEL_RST;
            mode_dly_ff  <= 2'h0;
        end else if (wr_mode) begin
            mode_pend_ff <= hwdata[3:0];
            mode_dly_ff  <= MODE_DELAY_CYC;
        end else if (mode_dly_ff != 2'h0) begin
            if (icyc) begin
                mode_dly_ff <= mode_dly_ff - 2'h1;
                if (mode_dly_ff == 2'h1) begin
                    mode_ff <= mode_pend_ff;
                end
            end
        end
    end

    // tick selection from prescaler bits
    logic tick_sel;
    logic pre_bit_ff;
    logic tick;

    always_comb begin
        unique case (mode_ff[2:0])
            3'h0:    tick_sel = pre_ff[10];
            3'h1:    tick_sel = pre_ff[9];
            3'h2:    tick_sel = pre_ff[8];
            3'h3:    tick_sel = pre_ff[6];
            3'h4:    tick_sel = pre_ff[4];
            3'h5:    tick_sel = pre_ff[2];
            3'h6:    tick_sel = pre_ff[1];
            default: tick_sel = pre_ff[0];
        endcase
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pre_bit_ff <= 1'b0;
        end else begin
            pre_bit_ff <= tick_sel;
        end
    end
    // falling edge of the chosen bit gives one tick per full period
    assign tick = pre_bit_ff & ~tick_sel;

    // ==========================================================
    // write register digits
    logic [3:0] load_low_ff;
    logic [3:0] load_high_ff;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            load_low_ff <= LOAD_LOW_RST;
        end else if (wr_low) begin
            load_low_ff <= hwdata[3:0];
        end
    end
    // upper digit has no reset by design
    always_ff @(posedge i_clk) begin
        if (wr_high) begin
            load_high_ff <= hwdata[3:0];
        end
    end

    // ==========================================================
    // counter
    logic [7:0] count_ff;
    logic       ovf;

    assign ovf = tick & (count_ff == COUNT_MAX);
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            count_ff <= COUNT_ZERO;
        end else if (wr_high) begin
            count_ff <= {hwdata[3:0], load_low_ff};
        end else if (ovf) begin
            if (mode_ff[RELOAD_SEL_BIT]) begin
                count_ff <= {load_high_ff, load_low_ff};
            end else begin
                count_ff <= COUNT_ZERO;
            end
        end else if (tick) begin
            count_ff <= count_ff + 8'h01;
        end
    end

    // ==========================================================
    // read latch for the low digit
    logic [3:0] read_low_ff;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            read_low_ff <= 4'h0;
        end else if (acc & ~hwrite & (haddr[13:2] == LOAD_HIGH_IDX)) begin
            read_low_ff <= count_ff[3:0];
        end
    end

    // ==========================================================
    // interrupt flag and watchdog enable
    logic irq_ff;
    logic wdog_ff;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            irq_ff <= 1'b0;
        end else if (ovf) begin
            irq_ff <= 1'b1;
        end else if (wr_irq & ~hwdata[IRQ_FLAG_BIT]) begin
            irq_ff <= 1'b0;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wdog_ff <= 1'b0;
        end else if (wr_wdog) begin
            wdog_ff <= hwdata[WDOG_EN_BIT];
        end
    end
    // registered so the reset request is a clean one-cycle pulse
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_chip_reset <= 1'b0;
        end else begin
            o_chip_reset <= ovf & wdog_ff;
        end
    end
    assign o_irq_flag = irq_ff;

    // ==========================================================
    // output mode register and timer output
    logic [2:0] out_mode_ff;
    logic       pwm_hi_ff;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            out_mode_ff <= OUT_MODE_RST;
        end else if (wr_out) begin
            out_mode_ff <= hwdata[2:0];
        end
    end
    assign o_pin_is_timer = (out_mode_ff != OM_PORT);

    // pwm: level flips at each overflow, high for every other reload interval
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pwm_hi_ff <= 1'b0;
        end else if (ovf) begin
            pwm_hi_ff <= ~pwm_hi_ff;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_timer_out <= 1'b0;
        end else if (ovf) begin
            case (out_mode_ff)
                OM_TOGGLE: o_timer_out <= ~o_timer_out;
                OM_FORCE0: o_timer_out <= 1'b0;
                OM_FORCE1: o_timer_out <= 1'b1;
                OM_PWM:    o_timer_out <= ~pwm_hi_ff;
                default:   o_timer_out <= o_timer_out;
            endcase
        end
    end

    // ==========================================================
    // read data
    always_comb begin
        hrdata = 32'h0000_0000;
        if (req_ff.rd) begin
            unique case (req_ff.idx)
                LOAD_LOW_IDX:  hrdata[3:0] = read_low_ff;
                LOAD_HIGH_IDX: hrdata[3:0] = count_ff[7:4];
                OUT_MODE_IDX:  hrdata[2:0] = out_mode_ff;
                IRQ_FLAG_IDX:  hrdata[IRQ_FLAG_BIT] = irq_ff;
                WDOG_IDX:      hrdata[WDOG_EN_BIT] = wdog_ff;
                default:       hrdata = 32'h0000_0000;
            endcase
        end
    end

    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, rd_high, hwdata[31:4], haddr[31:14], haddr[1:0]};

endmodule

// ===== rtw_pkg.sv
// package: register map, field layout and timing constants of the reload timer
package rtw_pkg;

    // ==========================================================
    // register offsets (word index; byte address is index * 4)
    localparam logic [11:0] MODE_SEL_IDX  = 12'h00D;
    localparam logic [11:0] LOAD_LOW_IDX  = 12'h00E;
    localparam logic [11:0] LOAD_HIGH_IDX = 12'h00F;
    localparam logic [11:0] OUT_MODE_IDX  = 12'h014;
    localparam logic [11:0] IRQ_FLAG_IDX  = 12'h002;
    localparam logic [11:0] WDOG_IDX      = 12'h020;

    // ==========================================================
    // field positions
    localparam int RELOAD_SEL_BIT = 3;
    localparam int IRQ_FLAG_BIT   = 2;
    localparam int WDOG_EN_BIT    = 1;

    // ==========================================================
    // reset values
    localparam logic [3:0] MODE_SEL_RST = 4'h0;
    localparam logic [2:0] OUT_MODE_RST = 3'h0;
    localparam logic [3:0] LOAD_LOW_RST = 4'h0;
    localparam logic [7:0] COUNT_MAX    = 8'hFF;
    localparam logic [7:0] COUNT_ZERO   = 8'h00;

    // ==========================================================
    // timing: one instruction cycle is this many system clocks
    localparam int          SYS_CLK_MHZ     = 250;
    localparam int          INSTR_CYCLE_NS  = 4;
    localparam int          INSTR_CYC_CLKS  = (INSTR_CYCLE_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int          PRESCALE_W      = 11;
    localparam logic [1:0]  MODE_DELAY_CYC  = 2'h2;

    // ==========================================================
    // output modes
    typedef enum logic [2:0] {
        OM_PORT   = 3'b000,
        OM_TOGGLE = 3'b001,
        OM_FORCE0 = 3'b010,
        OM_FORCE1 = 3'b011,
        OM_PWM    = 3'b111
    } rtw_out_mode_e;

    // ==========================================================
    // register bus request as seen after address phase
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] idx;
    } rtw_req_s;

endpackage

// ===== rtw_timer_assertions.sv
// checker: port-level assertions for the reload timer
`timescale 1ns/1ps
module rtw_timer_chk (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    // bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // timer side
    input wire logic        o_timer_out,
    input wire logic        o_pin_is_timer,
    input wire logic        o_irq_flag,
    input wire logic        o_chip_reset
);
    // ==========================================================
    // write address held through its data phase
    logic [7:0] wa_ff;
    always_ff @(posedge i_clk) begin
        wa_ff <= (hsel && hready && htrans[1] && hwrite) ? haddr[7:0] : 8'hFF;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // ==========================================================
    // assertions
    chk_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    chk_out_reset: assert property ($past(i_sys_rst) |-> !o_timer_out && !o_irq_flag)
        else $error("outputs not low after reset");
    chk_wdog_pulse: assert property (o_chip_reset |=> !o_chip_reset)
        else $error("chip reset longer than one cycle");
    chk_wdog_flag: assert property (o_chip_reset |-> o_irq_flag)
        else $error("chip reset without overflow flag");
    chk_flag_clear: assert property ($fell(o_irq_flag) && !$past(i_sys_rst)
        |-> $past(wa_ff) == 8'h08)
        else $error("flag cleared without software write");
    chk_pin_mode: assert property ($changed(o_pin_is_timer) && !$past(i_sys_rst)
        |-> $past(wa_ff) == 8'h50)
        else $error("pin function changed without mode write");
    chk_out_hold: assert property (!o_pin_is_timer && !$past(o_pin_is_timer)
        && !$past(i_sys_rst) |-> $stable(o_timer_out))
        else $error("timer output moved in port mode");
    cover property ($rose(o_irq_flag));
    cover property (o_chip_reset);
    cover property ($changed(o_timer_out));
endmodule

bind rtw_timer rtw_timer_chk i_chk (.i_clk, .i_sys_rst, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .o_timer_out, .o_pin_is_timer, .o_irq_flag, .o_chip_reset);

// ===== rtw_timer_tb_top.sv
// testbench: self-checking bench for the reload timer
`timescale 1ns/1ps
module rtw_timer_tb_top;
    import rtw_pkg::*;
    // ==========================================================
    // signals
    logic        i_clk     = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        hsel      = 1'b0;
    logic [31:0] haddr     = 32'h0;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'b0;
    logic [31:0] hwdata    = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [7:0]  v;
    logic        hreadyout, hresp, o_timer_out, o_pin_is_timer, o_irq_flag, o_chip_reset;
    logic        lv;
    int          n_fail = 0;
    int          checked = 0;
    int          n;
    int          m;
    int          per[8] = '{2048, 1024, 512, 128, 32, 8, 4, 2};
    always #2 i_clk = ~i_clk;
    rtw_timer i_dut (.i_clk, .i_sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .o_timer_out,
        .o_pin_is_timer, .o_irq_flag, .o_chip_reset);
    // ==========================================================
    // tasks
    task automatic test_done;
        if (n_fail == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // waits stay bounded so a dead bus ends the run
    task automatic rdy;
        n = 0;
        do begin @(posedge i_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin n_fail++; test_done; end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
        rdy;
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        rdy;
        rd = hrdata;
    endtask
    task automatic load(input logic [7:0] x);
        bus(1'b1, 8'h38, {28'h0, x[3:0]});
        bus(1'b1, 8'h3C, {28'h0, x[7:4]});
    endtask
    // cycles until the timer output next changes level
    task automatic edge_gap;
        lv = o_timer_out;
        n = 0;
        do begin @(negedge i_clk); n++; end while (o_timer_out === lv && n < 5000);
        if (o_timer_out === lv) begin n_fail++; test_done; end
    endtask
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(37));
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        bus(1'b0, 8'h50, 0); chk(rd, 0);
        bus(1'b1, 8'h44, 32'hFFFF); bus(1'b0, 8'h44, 0); chk(rd, 0);
        bus(1'b1, 8'h50, 1); bus(1'b0, 8'h50, 0); chk(rd, 1);
        chk(o_pin_is_timer, 1);
        for (int c = 7; c >= 0; c--) begin
            bus(1'b1, 8'h34, 8 + c); repeat (2) @(posedge i_clk);
            load(8'hFF); edge_gap; edge_gap; chk(n, per[c]);
        end
        chk(o_irq_flag, 1);
        bus(1'b1, 8'h08, 0); @(negedge i_clk);
        chk(o_irq_flag, 0);
        bus(1'b1, 8'h34, 7); repeat (2) @(posedge i_clk);
        load(8'hFF); edge_gap; edge_gap; chk(n, 512);
        v = 8'h40 + 8'($urandom % 8'hB0);
        bus(1'b1, 8'h34, 15); repeat (2) @(posedge i_clk);
        load(v); edge_gap; edge_gap; chk(n, (256 - v) * 2);
        repeat (2) begin
            m = o_timer_out ? 2 : 3;
            bus(1'b1, 8'h50, m); edge_gap; chk(o_timer_out, m == 3);
            repeat ((256 - v) * 2 + 4) @(posedge i_clk); chk(o_timer_out, m == 3);
        end
        bus(1'b1, 8'h50, 7); edge_gap; edge_gap; chk(n, (256 - v) * 2);
        bus(1'b1, 8'h50, 0); @(negedge i_clk);
        chk(o_pin_is_timer, 0);
        // slowest tick lets the count move at most one step while it is read
        bus(1'b1, 8'h34, 0); repeat (2) @(posedge i_clk);
        v = {4'($urandom), 4'($urandom % 13)};
        load(v); bus(1'b1, 8'h38, 3);
        bus(1'b0, 8'h3C, 0); chk(rd, v[7:4]);
        bus(1'b0, 8'h38, 0); chk(rd[3:0] - v[3:0] <= 1, 1);
        bus(1'b1, 8'h80, 2); bus(1'b1, 8'h34, 15); repeat (2) @(posedge i_clk);
        load(8'hFF); n = 0;
        while (o_chip_reset !== 1'b1 && n < 50) begin @(negedge i_clk); n++; end
        chk(o_chip_reset, 1);
        i_sys_rst <= 1'b1; repeat (10) @(posedge i_clk); i_sys_rst <= 1'b0;
        @(negedge i_clk); chk(o_timer_out, 0);
        bus(1'b1, 8'h3C, 6); bus(1'b0, 8'h3C, 0); chk(rd, 6);
        bus(1'b0, 8'h38, 0); chk(rd <= 1, 1);
        test_done;
    end
endmodule
